/* pm2_pwm.sv */
// pm2_pwm: two cooperating timer channels in two-register pwm mode with an
// apb register slave. the period channel clears both counters; the output
// channel's compare registers set each pin high.
// assumes an apb master on i_clk_sys and pins driving a load directly.
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/10ps

// How it works
// - duty spans zero to all but one tick from compares
// - period match clears counter, outputs low
// - duty match drives its output high
// - mode write drives initial low level
// - counter clear copies buffers into compares
// - clear during buffer write moves old value
// - write and match together: both happen
// - larger rewrite may match again this period
// - second match while high changes nothing
// - match interrupts when their enables set
// - sync start bits start both together
// - count start bits start both together
// - unbuffered compare write takes effect directly
module pm2_pwm
  import pm2_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_pwm_a,
  output logic o_pwm_b,
  output logic o_pwm_oe,
  output logic o_period_match_irq,
  output logic o_duty_a_match_irq,
  output logic o_duty_b_match_irq
);
  import pm2_pkg::*;

  // ****************************************
  // checks and state
  // ****************************************
  if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
    $error("CNT_W must be 2 to 16");
  end

  typedef struct packed {
    logic mode;
    logic buf_en;
    logic [1:0] psc;
    logic [2:0] ie;
    logic run0;
    logic run1;
    logic [CNT_W-1:0] cnt0;
    logic [CNT_W-1:0] cnt1;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] compare_reg_a;
    logic [CNT_W-1:0] compare_reg_b;
    logic [CNT_W-1:0] buffer_reg_c;
    logic [CNT_W-1:0] buffer_reg_d;
    logic out_a;
    logic out_b;
    logic [2:0] irq;
    logic [31:0] rdata;
  } pm2_state_t;

  pm2_state_t s_q;
  pm2_state_t s_d;
  logic tick;
  logic acc;
  logic wr;
  logic mapped;
  logic per_match;
  logic match_a;
  logic match_b;
  logic [CNT_W-1:0] wdat;

  pm2_prescaler u_psc (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_sel(s_q.psc),
    .o_tick(tick)
  );

  // ****************************************
  // bus decode
  // ****************************************
  always_comb begin
    case (i_paddr)
      PM2_OFF_CTRL, PM2_OFF_COUNT_START, PM2_OFF_SYNC_START, PM2_OFF_PERIOD,
      PM2_OFF_COMPARE_A, PM2_OFF_COMPARE_B, PM2_OFF_BUFFER_C,
      PM2_OFF_BUFFER_D, PM2_OFF_COUNT, PM2_OFF_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // one wait-free access phase: read data is captured during setup
  assign acc = i_psel & i_penable;
  assign wr = acc & i_pwrite & mapped;
  assign wdat = i_pwdata[CNT_W-1:0];
  assign o_pready = acc;
  assign o_pslverr = acc & ~mapped;
  assign o_prdata = s_q.rdata;

  // ****************************************
  // compare matches
  // ****************************************
  // matches look at the stored compare value, so a write in the same
  // cycle still lets the match through and stores the new value
  assign per_match = s_q.run1 & tick & (s_q.cnt1 == s_q.period);
  assign match_a = s_q.run0 & tick & (s_q.cnt0 == s_q.compare_reg_a);
  assign match_b = s_q.run0 & tick & (s_q.cnt0 == s_q.compare_reg_b);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.irq = '0;

    // counters; the period clear pulls the output channel along
    if (per_match) begin
      s_d.cnt1 = '0;
      s_d.cnt0 = '0;
    end else begin
      if (s_q.run1 && tick) begin
        s_d.cnt1 = s_q.cnt1 + 1'b1;
      end
      if (s_q.run0 && tick) begin
        s_d.cnt0 = s_q.cnt0 + 1'b1;
      end
    end

    // outputs: clear wins, so a compare above the period gives 0% and a
    // compare of zero goes high one tick after the clear, low for only that tick
    if (!s_q.mode) begin
      s_d.out_a = PM2_INIT_LEVEL;
      s_d.out_b = PM2_INIT_LEVEL;
    end else if (per_match) begin
      s_d.out_a = 1'b0;
      s_d.out_b = 1'b0;
    end else begin
      if (match_a) begin
        s_d.out_a = 1'b1;
      end
      if (match_b) begin
        s_d.out_b = 1'b1;
      end
    end

    s_d.irq[0] = per_match & s_q.ie[0];
    s_d.irq[1] = match_a & s_q.ie[1];
    s_d.irq[2] = match_b & s_q.ie[2];

    // transfer reads the old buffer contents even if written now
    if (s_q.buf_en && per_match) begin
      s_d.compare_reg_a = s_q.buffer_reg_c;
      s_d.compare_reg_b = s_q.buffer_reg_d;
    end

    // register writes; a direct compare write beats a same-cycle transfer
    if (wr) begin
      case (i_paddr)
        PM2_OFF_CTRL: begin
          s_d.mode = i_pwdata[PM2_CTRL_MODE];
          s_d.buf_en = i_pwdata[PM2_CTRL_BUF];
          s_d.psc = i_pwdata[PM2_CTRL_PSC +: 2];
          s_d.ie = i_pwdata[PM2_CTRL_IE_PER +: 3];
          if (i_pwdata[PM2_CTRL_MODE]) begin
            s_d.out_a = PM2_INIT_LEVEL;
            s_d.out_b = PM2_INIT_LEVEL;
          end
        end
        PM2_OFF_COUNT_START: begin
          s_d.run0 = i_pwdata[PM2_START_CH_ZERO];
          s_d.run1 = i_pwdata[PM2_START_CH_ONE];
        end
        PM2_OFF_SYNC_START: begin
          // set-only: a zero bit leaves its channel as it was
          if (i_pwdata[PM2_START_CH_ZERO]) begin
            s_d.run0 = 1'b1;
          end
          if (i_pwdata[PM2_START_CH_ONE]) begin
            s_d.run1 = 1'b1;
          end
        end
        PM2_OFF_PERIOD: s_d.period = wdat;
        PM2_OFF_COMPARE_A: s_d.compare_reg_a = wdat;
        PM2_OFF_COMPARE_B: s_d.compare_reg_b = wdat;
        PM2_OFF_BUFFER_C: s_d.buffer_reg_c = wdat;
        PM2_OFF_BUFFER_D: s_d.buffer_reg_d = wdat;
        default: s_d.mode = s_q.mode;
      endcase
    end

    // read capture in the setup cycle keeps prdata a flop output
    if (i_psel && !i_penable) begin
      s_d.rdata = '0;
      case (i_paddr)
        PM2_OFF_CTRL: begin
          s_d.rdata[PM2_CTRL_MODE] = s_q.mode;
          s_d.rdata[PM2_CTRL_BUF] = s_q.buf_en;
          s_d.rdata[PM2_CTRL_PSC +: 2] = s_q.psc;
          s_d.rdata[PM2_CTRL_IE_PER +: 3] = s_q.ie;
        end
        PM2_OFF_COUNT_START: s_d.rdata[1:0] = {s_q.run1, s_q.run0};
        PM2_OFF_PERIOD: s_d.rdata[CNT_W-1:0] = s_q.period;
        PM2_OFF_COMPARE_A: s_d.rdata[CNT_W-1:0] = s_q.compare_reg_a;
        PM2_OFF_COMPARE_B: s_d.rdata[CNT_W-1:0] = s_q.compare_reg_b;
        PM2_OFF_BUFFER_C: s_d.rdata[CNT_W-1:0] = s_q.buffer_reg_c;
        PM2_OFF_BUFFER_D: s_d.rdata[CNT_W-1:0] = s_q.buffer_reg_d;
        PM2_OFF_COUNT: begin
          s_d.rdata[CNT_W-1:0] = s_q.cnt0;
          s_d.rdata[PM2_COUNT_HI +: CNT_W] = s_q.cnt1;
        end
        PM2_OFF_STATUS: begin
          s_d.rdata[PM2_STAT_OUT_A] = s_q.out_a;
          s_d.rdata[PM2_STAT_OUT_B] = s_q.out_b;
          s_d.rdata[PM2_STAT_RUN0] = s_q.run0;
          s_d.rdata[PM2_STAT_RUN1] = s_q.run1;
        end
        default: s_d.rdata = '0;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.psc <= PM2_RST_PSC;
      s_q.period <= PM2_RST_PERIOD[CNT_W-1:0];
      s_q.compare_reg_a <= PM2_RST_COMPARE[CNT_W-1:0];
      s_q.compare_reg_b <= PM2_RST_COMPARE[CNT_W-1:0];
      s_q.buffer_reg_c <= PM2_RST_COMPARE[CNT_W-1:0];
      s_q.buffer_reg_d <= PM2_RST_COMPARE[CNT_W-1:0];
    end else begin
      s_q <= s_d;
    end
  end

  assign o_pwm_a = s_q.out_a;
  assign o_pwm_b = s_q.out_b;
  assign o_pwm_oe = s_q.mode;
  assign o_period_match_irq = s_q.irq[0];
  assign o_duty_a_match_irq = s_q.irq[1];
  assign o_duty_b_match_irq = s_q.irq[2];

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  logic wr_ca;
  logic wr_bc;
  assign wr_ca = wr && i_paddr == PM2_OFF_COMPARE_A;
  assign wr_bc = wr && i_paddr == PM2_OFF_BUFFER_C;

  property p_clear_both;
    per_match |=> s_q.cnt1 == '0 && s_q.cnt0 == '0;
  endproperty
  a_clear_both: assert property (p_clear_both)
    else $error("period match did not clear both counters");

  property p_low_on_clear;
    per_match && s_q.mode && !wr |=> !o_pwm_a && !o_pwm_b;
  endproperty
  a_low_on_clear: assert property (p_low_on_clear)
    else $error("outputs not low after period match");

  property p_high_on_a;
    match_a && !per_match && s_q.mode && !wr |=> o_pwm_a ##1 o_pwm_a || $past(per_match);
  endproperty
  a_high_on_a: assert property (p_high_on_a)
    else $error("output a not high after its match");

  property p_init_low;
    wr && i_paddr == PM2_OFF_CTRL && i_pwdata[PM2_CTRL_MODE] |=> !o_pwm_a && !o_pwm_b && o_pwm_oe;
  endproperty
  a_init_low: assert property (p_init_low)
    else $error("mode write did not show initial level");

  property p_buf_xfer;
    s_q.buf_en && per_match && !wr |=> s_q.compare_reg_a == $past(s_q.buffer_reg_c) &&
      s_q.compare_reg_b == $past(s_q.buffer_reg_d);
  endproperty
  a_buf_xfer: assert property (p_buf_xfer)
    else $error("buffers not moved at counter clear");

  property p_old_buf;
    s_q.buf_en && per_match && wr_bc |=> s_q.compare_reg_a == $past(s_q.buffer_reg_c) &&
      s_q.buffer_reg_c == $past(wdat);
  endproperty
  a_old_buf: assert property (p_old_buf)
    else $error("clear during buffer write moved the new value");

  property p_write_and_match;
    match_a && wr_ca && s_q.ie[1] |=> o_duty_a_match_irq && s_q.compare_reg_a == $past(wdat);
  endproperty
  a_write_and_match: assert property (p_write_and_match)
    else $error("write lost or match dropped on contention");

  property p_stay_high;
    o_pwm_a && match_a && !per_match && s_q.mode |=> o_pwm_a;
  endproperty
  a_stay_high: assert property (p_stay_high)
    else $error("second match changed a high output");

  property p_irq_period;
    per_match |=> o_period_match_irq == $past(s_q.ie[0]) ##1 !o_period_match_irq || $past(per_match);
  endproperty
  a_irq_period: assert property (p_irq_period)
    else $error("period interrupt wrong");

  property p_sync_start;
    wr && i_paddr == PM2_OFF_SYNC_START && i_pwdata[1:0] == 2'h3 |=> s_q.run0 && s_q.run1;
  endproperty
  a_sync_start: assert property (p_sync_start)
    else $error("sync start did not start both channels");

  property p_count_start;
    wr && i_paddr == PM2_OFF_COUNT_START && i_pwdata[1:0] == 2'h3 |=> s_q.run0 && s_q.run1;
  endproperty
  a_count_start: assert property (p_count_start)
    else $error("count start did not start both channels");

  property p_direct;
    wr_ca && !s_q.buf_en |=> s_q.compare_reg_a == $past(wdat);
  endproperty
  a_direct: assert property (p_direct)
    else $error("unbuffered compare write not direct");

  c_full_period: cover property (per_match ##[1:1000] match_a ##[1:1000] per_match);
  c_buf_contention: cover property (s_q.buf_en && per_match && wr_bc);
  c_double_match: cover property (match_a && o_pwm_a && s_q.mode);
  c_write_match: cover property (match_a && wr_ca);

endmodule

/* pm2_pkg.sv */
// pm2_pkg: register map, field positions, reset values and divider
// settings shared by the two-channel pwm block and its prescaler.
// assumes a 32-bit apb bus with byte addresses.
package pm2_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] PM2_OFF_CTRL = 8'h00;
  localparam logic [7:0] PM2_OFF_COUNT_START = 8'h04;
  localparam logic [7:0] PM2_OFF_SYNC_START = 8'h08;
  localparam logic [7:0] PM2_OFF_PERIOD = 8'h0c;
  localparam logic [7:0] PM2_OFF_COMPARE_A = 8'h10;
  localparam logic [7:0] PM2_OFF_COMPARE_B = 8'h14;
  localparam logic [7:0] PM2_OFF_BUFFER_C = 8'h18;
  localparam logic [7:0] PM2_OFF_BUFFER_D = 8'h1c;
  localparam logic [7:0] PM2_OFF_COUNT = 8'h20;
  localparam logic [7:0] PM2_OFF_STATUS = 8'h24;

  // ****************************************
  // field positions
  // ****************************************
  // pwm_mode_reg lives in ctrl bit 0
  localparam int PM2_CTRL_MODE = 0;
  localparam int PM2_CTRL_BUF = 1;
  localparam int PM2_CTRL_PSC = 2;
  localparam int PM2_CTRL_IE_PER = 4;
  localparam int PM2_CTRL_IE_A = 5;
  localparam int PM2_CTRL_IE_B = 6;
  localparam int PM2_START_CH_ZERO = 0;
  localparam int PM2_START_CH_ONE = 1;
  localparam int PM2_STAT_OUT_A = 0;
  localparam int PM2_STAT_OUT_B = 1;
  localparam int PM2_STAT_RUN0 = 2;
  localparam int PM2_STAT_RUN1 = 3;
  localparam int PM2_COUNT_HI = 16;

  // ****************************************
  // reset values and prescaler
  // ****************************************
  localparam logic [15:0] PM2_RST_PERIOD = 16'hffff;
  localparam logic [15:0] PM2_RST_COMPARE = 16'hffff;
  localparam logic [1:0] PM2_RST_PSC = 2'h0;
  localparam logic PM2_INIT_LEVEL = 1'b0;
  // divide by 1, 2, 4, 8: tick when the low bits of the count are all ones
  localparam logic [2:0] PM2_PSC_MASK_DIV1 = 3'h0;
  localparam logic [2:0] PM2_PSC_MASK_DIV2 = 3'h1;
  localparam logic [2:0] PM2_PSC_MASK_DIV4 = 3'h3;
  localparam logic [2:0] PM2_PSC_MASK_DIV8 = 3'h7;

endpackage

/* pm2_prescaler.sv */
// pm2_prescaler: makes the count-clock enable pulse from the system clock.
// assumes i_sel comes from a register on the same clock.
`timescale 1ns/10ps
module pm2_prescaler
  import pm2_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [1:0] i_sel,
  output logic o_tick
);
  import pm2_pkg::*;

  typedef struct packed {
    logic [2:0] cnt;
  } pm2_psc_state_t;

  pm2_psc_state_t s_q;
  pm2_psc_state_t s_d;
  logic [2:0] mask;

  always_comb begin
    case (i_sel)
      2'h0: mask = PM2_PSC_MASK_DIV1;
      2'h1: mask = PM2_PSC_MASK_DIV2;
      2'h2: mask = PM2_PSC_MASK_DIV4;
      default: mask = PM2_PSC_MASK_DIV8;
    endcase
  end

  // free running so both channels see the very same tick
  always_comb begin
    s_d = s_q;
    s_d.cnt = s_q.cnt + 3'h1;
  end

  assign o_tick = ((s_q.cnt & mask) == mask);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

/* tb_pm2_pwm.sv */
// tb_pm2_pwm: self-checking bench for the two-channel pwm block.
// assumes a zero-wait apb slave and a prescaler that ticks every cycle at /1.
`timescale 1ns/10ps
module tb_pm2_pwm;
  import pm2_pkg::*;
  // ****************************************
  // signals and dut
  // ****************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pwm_a, pwm_b, pwm_oe;
  logic period_match_irq, duty_a_match_irq, duty_b_match_irq;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  int per = 9;
  logic [31:0] q;
  logic e;
  int ha, hb, na, nb, n;

  always #5 clk = ~clk;

  pm2_pwm #(.CNT_W(16)) dut (.i_clk_sys(clk), .i_rst(rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_pwm_a(pwm_a),
    .o_pwm_b(pwm_b), .o_pwm_oe(pwm_oe), .o_period_match_irq(period_match_irq),
    .o_duty_a_match_irq(duty_a_match_irq), .o_duty_b_match_irq(duty_b_match_irq));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic finish_test();
    if (errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // called just after a rising edge; the extra edge at the end keeps
  // back-to-back calls from assigning psel twice in one time step
  // waits for pready as long as it takes; only the bench timeout ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // returns at the falling edge inside the cycle where counters read zero
  task automatic wait_irq();
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (period_match_irq !== 1'b1 && k < 4000);
    if (k >= 4000) errors++;
  endtask

  task automatic measure();
    ha = 0;
    hb = 0;
    na = 0;
    nb = 0;
    wait_irq();
    repeat (per + 1) begin
      if (pwm_a === 1'b1) ha++;
      if (pwm_b === 1'b1) hb++;
      if (duty_a_match_irq === 1'b1) na++;
      if (duty_b_match_irq === 1'b1) nb++;
      @(negedge clk);
    end
    @(posedge clk);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rd(PM2_OFF_PERIOD);
    check(q, 32'h0000ffff);
    rd(PM2_OFF_BUFFER_C);
    check(q, 32'h0000ffff);
    rd(8'h40);
    check({31'h0, e}, 32'h1);
    wr(PM2_OFF_STATUS, 32'hf);
    rd(PM2_OFF_STATUS);
    check(q, 32'h0);
  endtask

  task automatic t_mode();
    wr(PM2_OFF_CTRL, 32'h71);
    @(negedge clk);
    check({29'h0, pwm_oe, pwm_a, pwm_b}, 32'h4);
    @(posedge clk);
  endtask

  task automatic t_duty();
    wr(PM2_OFF_PERIOD, per);
    wr(PM2_OFF_COMPARE_A, 32'h3);
    wr(PM2_OFF_COMPARE_B, per + 1);
    wr(PM2_OFF_SYNC_START, 32'h3);
    rd(PM2_OFF_COUNT);
    check(q[15:0], q[31:16]);
    rd(PM2_OFF_STATUS);
    check(q[3:2], 2'b11);
    measure();
    check(ha, per - 3);
    check(hb, 0);
    check(na, 1);
    wr(PM2_OFF_COMPARE_A, 32'h0);
    measure();
    check(ha, per);
    wr(PM2_OFF_CTRL, 32'h1);
    na = 0;
    repeat (2 * per + 4) begin
      @(negedge clk);
      if (duty_a_match_irq === 1'b1 || period_match_irq === 1'b1) na++;
    end
    check(na, 0);
    @(posedge clk);
    wr(PM2_OFF_CTRL, 32'h71);
  endtask

  // a larger compare written after its match matches again, output stays high
  task automatic t_recmp();
    per = 39;
    wr(PM2_OFF_PERIOD, per);
    wr(PM2_OFF_COMPARE_A, 32'h5);
    wait_irq();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (duty_a_match_irq !== 1'b1 && n < 100);
    @(posedge clk);
    wr(PM2_OFF_COMPARE_A, 32'd30);
    ha = 0;
    na = 0;
    n = 0;
    @(negedge clk);
    while (period_match_irq !== 1'b1 && n < 100) begin
      if (pwm_a !== 1'b1) ha++;
      if (duty_a_match_irq === 1'b1) na++;
      @(negedge clk);
      n++;
    end
    check(na, 1);
    check(ha, 0);
    @(posedge clk);
    measure();
    check(ha, per - 30);
    check(hb, per - 10);
    check(nb, 1);
    // rewrite compare a in the very cycle that it matches 30: the pin must
    // still rise at 31, long before the new value 35 could set it
    repeat (28) @(posedge clk);
    wr(PM2_OFF_COMPARE_A, 32'd35);
    @(negedge clk);
    check({31'h0, pwm_a}, 32'h1);
    @(posedge clk);
    rd(PM2_OFF_COMPARE_A);
    check(q, 32'd35);
  endtask

  task automatic t_buf();
    wr(PM2_OFF_CTRL, 32'h73);
    wr(PM2_OFF_BUFFER_C, 32'd10);
    wr(PM2_OFF_BUFFER_D, 32'd7);
    wait_irq();
    @(posedge clk);
    rd(PM2_OFF_COMPARE_A);
    check(q, 32'd10);
    rd(PM2_OFF_COMPARE_B);
    check(q, 32'd7);
    wait_irq();
    @(posedge clk);
    // the write's storing edge lands exactly on the counter clear edge
    repeat (per - 2) @(posedge clk);
    wr(PM2_OFF_BUFFER_C, 32'd20);
    rd(PM2_OFF_COMPARE_A);
    check(q, 32'd10);
    wait_irq();
    @(posedge clk);
    rd(PM2_OFF_COMPARE_A);
    check(q, 32'd20);
  endtask

  task automatic t_start();
    wr(PM2_OFF_COUNT_START, 32'h0);
    wr(PM2_OFF_CTRL, 32'h19);
    wr(PM2_OFF_COUNT_START, 32'h3);
    rd(PM2_OFF_COUNT);
    check(q[15:0], q[31:16]);
    wait_irq();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (period_match_irq !== 1'b1 && n < 1000);
    check(n, (per + 1) * 4);
    rd(PM2_OFF_COUNT);
    check(q[15:0], q[31:16]);
  endtask

  // ****************************************
  // main sequence and timeout
  // ****************************************
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_mode();
    t_duty();
    t_recmp();
    t_buf();
    t_start();
    finish_test();
  end
endmodule
